// file: design/sfcp_pkg.sv
// Constants, encodings and reset values for the serial flash command port.
// Assumes a single 10 MHz system clock; serial pins are asynchronous to it.
package sfcp_pkg;

  // Opcodes
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_SSE_A      = 8'hd7;
  localparam logic [7:0] OP_SSE_B      = 8'h20;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_WRITE_EN   = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS  = 8'h04;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_STAT_READ  = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_ID_READ    = 8'h9f;
  localparam logic [7:0] OP_ID_WAKE    = 8'hab;

  // Byte counts of complete commands, byte count cap and byte/bit indices
  localparam logic [2:0] BYTES_SINGLE   = 3'h1;
  localparam logic [2:0] BYTES_STATUS_W = 3'h2;
  localparam logic [2:0] BYTES_ADDR     = 3'h4;
  localparam logic [2:0] BYTES_PROG_MIN = 3'h5;
  localparam logic [2:0] BYTE_CNT_MAX   = 3'h7;
  localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
  localparam logic [2:0] BYTE_DUMMY     = 3'h4;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  // Address space
  localparam int          ADDR_W        = 18;
  localparam logic [17:0] PROT_QUARTER  = 18'h30000;
  localparam logic [17:0] PROT_HALF     = 18'h20000;

  // Status layout
  localparam int          ST_BUSY       = 0;
  localparam int          ST_WEL        = 1;
  localparam int          ST_BP_LO      = 2;
  localparam int          ST_BP_HI      = 3;
  localparam int          ST_SWP        = 7;
  localparam logic [1:0]  BP_RST        = 2'h0;
  localparam logic        SWP_RST       = 1'h0;

  // Identification bytes (values are arbitrary)
  localparam logic [7:0]  ID_MAKER      = 8'h5a;
  localparam logic [7:0]  ID_DEVICE     = 8'h3c;

  // Synchroniser reset: {write_protect_n, si, sck, cs_n}
  localparam logic [3:0]  PIN_RST       = 4'h9;

  // Program data buffer
  localparam int          FIFO_W        = 8;
  localparam int          FIFO_DEPTH    = 32;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_CMD    = 2'b01,
    PH_OUT    = 2'b10,
    PH_IGNORE = 2'b11
  } sfcp_phase_e;

  typedef enum logic [1:0] {
    SRC_MEM    = 2'b00,
    SRC_STATUS = 2'b01,
    SRC_ID_SEQ = 2'b10,
    SRC_ID_DEV = 2'b11
  } sfcp_src_e;

  typedef enum logic [1:0] {
    ARR_SMALL_ERASE  = 2'b00,
    ARR_SECTOR_ERASE = 2'b01,
    ARR_CHIP_ERASE   = 2'b10,
    ARR_PROGRAM      = 2'b11
  } sfcp_arr_e;

endpackage

// file: design/sfcp_fifo.sv
// Parameterised flop FIFO with valid/ready on both sides and a flush.
// Assumes one clock domain; DEPTH is a power of two.
`timescale 1ns/1ps
module sfcp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  // System
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         clear,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  import sfcp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } sfcp_fifo_s;

  sfcp_fifo_s r;
  sfcp_fifo_s n;
  logic       push;
  logic       pop;

  assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    n = r;
    if (clear) begin
      n.wr  = '0;
      n.rd  = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[r.wr] = in_data;
        n.wr        = r.wr + 1'b1;
      end
      if (pop) begin
        n.rd = r.rd + 1'b1;
      end
      n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule // sfcp_fifo

// file: design/sfcp_cmd_port.sv
// Slave command front end of a serial flash: pin sampling, opcode decode,
// read streaming, status register and array command issue.
// Assumes serial pins asynchronous to clock, sck at most clock/8, and an
// array that returns mem_rdata one cycle after mem_rd and pulses arr_done.
//
// Behaviour
// - Chip select falling selects the device and opens command input.
// - Input bits shift in msb first on sck rise; output stays off meanwhile.
// - Reads drive output on, msb first, on sck falling edges.
// - Sck level at chip select fall picks mode 0 or mode 3.
// - Opcode 03h plus three address bytes returns data from that address.
// - 03h data starts on the fall after the last address bit.
// - Opcode 0Bh takes three address bytes plus one ignored dummy byte.
// - 0Bh data starts on the fall after the dummy byte.
// - Read address increments per byte and wraps from top to zero.
// - Chip select high ends the cycle and turns the output off.
// - Only the low 18 address bits are kept.
// - Non-read commands other than ABh act only if select rises on a byte boundary.
// - D7h/20h small sector erase, D8h sector erase, C7h chip erase.
// - ABh leaves power down.
// - 9Fh and ABh plus three bytes return identification bytes.
// - 05h reads status; 01h plus one byte writes status.
// - Status holds busy, write enable latch and reserved zero bits.
// - Bit 7 is the status write protect flag.
// - Bits 2 and 3 are the kept block protect level.
// - Status read repeats bit 7 to bit 0 while the clock runs.
// - Status write needs write enable and either protect pin high or flag 0.
// - Write enable latch clears on reset and on write completion.
// - Protect level guards quarter, half or all; chip erase only at 0.
`timescale 1ns/1ps
module sfcp_cmd_port (
  // System
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Serial pins
  input  wire logic                      cs_n,
  input  wire logic                      sck,
  input  wire logic                      si,
  input  wire logic                      write_protect_n,
  output logic                           so,
  output logic                           so_oe,
  // Array read
  output logic                           mem_rd,
  output logic [sfcp_pkg::ADDR_W-1:0]    mem_addr,
  input  wire logic [7:0]                mem_rdata,
  // Array operations
  output logic                           arr_cmd_valid,
  output sfcp_pkg::sfcp_arr_e            arr_cmd_kind,
  output logic [sfcp_pkg::ADDR_W-1:0]    arr_cmd_addr,
  input  wire logic                      arr_done,
  // Program data
  output logic [sfcp_pkg::FIFO_W-1:0]    program_data_byte,
  output logic                           program_data_valid,
  input  wire logic                      program_data_ready,
  // Status view
  output logic [7:0]                     flash_status,
  output logic                           power_down
);
  import sfcp_pkg::*;

  typedef struct packed {
    logic [3:0]        pin_s1;
    logic [3:0]        pin_s2;
    logic              cs_d;
    logic              sck_d;
    sfcp_phase_e       phase;
    sfcp_src_e         src;
    logic              mode3;
    logic              seen_rise;
    logic [2:0]        bit_cnt;
    logic [2:0]        byte_cnt;
    logic [2:0]        out_cnt;
    logic [6:0]        rx;
    logic [7:0]        opcode;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        tx;
    logic [7:0]        next_byte;
    logic              id_sel;
    logic              rd_wait;
    logic              prog_ok;
    logic              push_pend;
    logic [7:0]        push_byte;
    logic              overrun;
    logic              wel;
    logic [1:0]        bp;
    logic              swp;
    logic              busy;
    logic              power_down;
    logic [7:0]        stat;
    logic              so;
    logic              so_oe;
    logic              mem_rd;
    logic [ADDR_W-1:0] mem_addr;
    logic              arr_valid;
    sfcp_arr_e         arr_kind;
    logic [ADDR_W-1:0] arr_addr;
    logic              fifo_clear;
  } sfcp_state_s;

  sfcp_state_s       r;
  sfcp_state_s       n;
  logic              fifo_in_ready;
  logic [7:0]        byte_in;
  logic              cs_high;
  logic              cs_fall;
  logic              cs_rise;
  logic              sck_rise;
  logic              sck_fall;
  logic              byte_done;
  logic              start_read;
  logic [ADDR_W-1:0] start_addr;

  function automatic logic is_prot(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
    case (lvl)
      2'h0:    is_prot = 1'b0;
      2'h1:    is_prot = (a >= PROT_QUARTER);
      2'h2:    is_prot = (a >= PROT_HALF);
      default: is_prot = 1'b1;
    endcase
  endfunction

  assign cs_high   = r.pin_s2[0];
  assign byte_in   = {r.rx, r.pin_s2[2]};
  assign cs_fall   = r.cs_d & ~cs_high;
  assign cs_rise   = ~r.cs_d & cs_high;
  assign sck_rise  = ~r.sck_d & r.pin_s2[1] & ~cs_high & (r.phase != PH_IDLE);
  assign sck_fall  = r.sck_d & ~r.pin_s2[1] & ~cs_high & (r.phase == PH_OUT)
                     & (~r.mode3 | r.seen_rise);
  assign byte_done = sck_rise & (r.bit_cnt == BIT_LAST);

  always_comb begin
    n          = r;
    start_read = 1'b0;
    start_addr = r.addr;
    n.pin_s1   = {write_protect_n, si, sck, cs_n};
    n.pin_s2   = r.pin_s1;
    n.cs_d     = r.pin_s2[0];
    n.sck_d    = r.pin_s2[1];
    n.mem_rd     = 1'b0;
    n.arr_valid  = 1'b0;
    n.fifo_clear = 1'b0;
    n.rd_wait    = r.mem_rd;
    if (r.rd_wait) begin
      n.next_byte = mem_rdata;
    end
    if (r.push_pend && fifo_in_ready) begin
      n.push_pend = 1'b0;
    end
    if (arr_done) begin
      n.busy = 1'b0;
      n.wel  = 1'b0;
    end
    if (cs_fall) begin
      n.phase     = PH_CMD;
      n.mode3     = r.pin_s2[1];
      n.seen_rise = 1'b0;
      n.bit_cnt   = '0;
      n.byte_cnt  = '0;
      n.overrun   = 1'b0;
      n.prog_ok   = 1'b0;
    end else if (cs_rise && r.phase == PH_CMD && r.bit_cnt == '0) begin
      case (r.opcode)
        OP_WRITE_EN: begin
          if (r.byte_cnt == BYTES_SINGLE) n.wel = 1'b1;
        end
        OP_WRITE_DIS: begin
          if (r.byte_cnt == BYTES_SINGLE) n.wel = 1'b0;
        end
        OP_POWER_DOWN: begin
          if (r.byte_cnt == BYTES_SINGLE && !r.busy) n.power_down = 1'b1;
        end
        OP_STAT_WRITE: begin
          if (r.byte_cnt == BYTES_STATUS_W && r.wel && !r.busy
              && (r.pin_s2[3] || !r.swp)) begin
            n.bp  = r.wdata[ST_BP_HI:ST_BP_LO];
            n.swp = r.wdata[ST_SWP];
            n.wel = 1'b0;
          end
        end
        OP_CHIP_ERASE: begin
          if (r.byte_cnt == BYTES_SINGLE && r.wel && !r.busy && r.bp == 2'h0) begin
            n.arr_valid = 1'b1;
            n.arr_kind  = ARR_CHIP_ERASE;
          end
        end
        OP_SSE_A, OP_SSE_B, OP_SECT_ERASE: begin
          if (r.byte_cnt == BYTES_ADDR && r.wel && !r.busy && !is_prot(r.bp, r.addr)) begin
            n.arr_valid = 1'b1;
            n.arr_kind  = (r.opcode == OP_SECT_ERASE) ? ARR_SECTOR_ERASE : ARR_SMALL_ERASE;
          end
        end
        OP_PAGE_PROG: begin
          if (r.byte_cnt >= BYTES_PROG_MIN && r.prog_ok && !r.overrun) begin
            n.arr_valid = 1'b1;
            n.arr_kind  = ARR_PROGRAM;
          end
        end
        default: begin
        end
      endcase
      if (n.arr_valid) begin
        n.arr_addr = r.addr;
        n.busy     = 1'b1;
      end
      n.phase = PH_IDLE;
    end else if (cs_rise) begin
      n.phase = PH_IDLE;
    end else if (sck_rise) begin
      n.seen_rise = 1'b1;
      n.rx        = byte_in[6:0];
      n.bit_cnt   = r.bit_cnt + 3'h1;
      if (byte_done) begin
        if (r.byte_cnt != BYTE_CNT_MAX) n.byte_cnt = r.byte_cnt + 3'h1;
        if (r.phase == PH_CMD) begin
          case (r.byte_cnt)
            3'h0: begin
              n.opcode = byte_in;
              if (r.power_down && byte_in != OP_ID_WAKE) begin
                n.phase = PH_IGNORE;
              end else begin
                case (byte_in)
                  OP_STAT_READ: begin
                    n.phase     = PH_OUT;
                    n.src       = SRC_STATUS;
                    n.next_byte = r.stat;
                    n.out_cnt   = '0;
                  end
                  OP_ID_READ: begin
                    n.phase     = PH_OUT;
                    n.src       = SRC_ID_SEQ;
                    n.next_byte = ID_MAKER;
                    n.id_sel    = 1'b1;
                    n.out_cnt   = '0;
                  end
                  OP_ID_WAKE: begin
                    n.power_down = 1'b0;
                  end
                  OP_PAGE_PROG: begin
                    n.prog_ok    = r.wel & ~r.busy;
                    n.fifo_clear = r.wel & ~r.busy;
                  end
                  OP_READ, OP_FAST_READ, OP_SSE_A, OP_SSE_B, OP_SECT_ERASE,
                  OP_CHIP_ERASE, OP_WRITE_EN, OP_WRITE_DIS, OP_POWER_DOWN,
                  OP_STAT_WRITE: begin
                  end
                  default: begin
                    n.phase = PH_IGNORE;
                  end
                endcase
              end
            end
            3'h1: begin
              n.addr[ADDR_W-1:16] = byte_in[ADDR_W-17:0];
              n.wdata             = byte_in;
            end
            3'h2: begin
              n.addr[15:8] = byte_in;
            end
            3'h3: begin
              n.addr[7:0] = byte_in;
              start_addr  = {r.addr[ADDR_W-1:8], byte_in};
              start_read  = (r.opcode == OP_READ);
              if (r.opcode == OP_PAGE_PROG) n.prog_ok = r.prog_ok & ~is_prot(r.bp, start_addr);
              if (r.opcode == OP_ID_WAKE) begin
                n.phase     = PH_OUT;
                n.src       = SRC_ID_DEV;
                n.next_byte = ID_DEVICE;
                n.out_cnt   = '0;
              end
            end
            default: begin
              start_read = (r.opcode == OP_FAST_READ) && (r.byte_cnt == BYTE_DUMMY);
            end
          endcase
          if (r.opcode == OP_PAGE_PROG && r.byte_cnt >= BYTE_DUMMY && r.prog_ok) begin
            if (r.push_pend && !fifo_in_ready) begin
              n.overrun = 1'b1;
            end else begin
              n.push_pend = 1'b1;
              n.push_byte = byte_in;
            end
          end
        end
      end
      if (start_read) begin
        n.phase    = PH_OUT;
        n.src      = SRC_MEM;
        n.out_cnt  = '0;
        n.mem_rd   = 1'b1;
        n.mem_addr = start_addr;
        n.addr     = start_addr + 1'b1;
      end
    end else if (sck_fall) begin
      n.so_oe   = 1'b1;
      n.out_cnt = r.out_cnt + 3'h1;
      if (r.out_cnt == '0) begin
        n.so = r.next_byte[7];
        n.tx = {r.next_byte[6:0], 1'b0};
        case (r.src)
          SRC_MEM: begin
            n.mem_rd   = 1'b1;
            n.mem_addr = r.addr;
            n.addr     = r.addr + 1'b1;
          end
          SRC_STATUS: n.next_byte = r.stat;
          SRC_ID_SEQ: begin
            n.next_byte = r.id_sel ? ID_DEVICE : ID_MAKER;
            n.id_sel    = ~r.id_sel;
          end
          default: n.next_byte = ID_DEVICE;
        endcase
      end else begin
        n.so = r.tx[7];
        n.tx = {r.tx[6:0], 1'b0};
      end
    end
    if (cs_high || n.phase != PH_OUT) begin
      n.so_oe = 1'b0;
    end
    n.stat = {n.swp, 3'h0, n.bp, n.wel, n.busy};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r        <= '0;
      r.pin_s1 <= PIN_RST;
      r.pin_s2 <= PIN_RST;
      r.cs_d   <= 1'b1;
      r.bp     <= BP_RST;
      r.swp    <= SWP_RST;
      r.stat   <= {SWP_RST, 3'h0, BP_RST, 2'h0};
    end else begin
      r <= n;
    end
  end

  sfcp_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_prog_fifo (
    .clock     (clock),
    .rst       (rst),
    .clear     (r.fifo_clear),
    .in_data   (r.push_byte),
    .in_valid  (r.push_pend),
    .in_ready  (fifo_in_ready),
    .out_data  (program_data_byte),
    .out_valid (program_data_valid),
    .out_ready (program_data_ready)
  );

  assign so            = r.so;
  assign so_oe         = r.so_oe;
  assign mem_rd        = r.mem_rd;
  assign mem_addr      = r.mem_addr;
  assign arr_cmd_valid = r.arr_valid;
  assign arr_cmd_kind  = r.arr_kind;
  assign arr_cmd_addr  = r.arr_addr;
  assign flash_status  = r.stat;
  assign power_down    = r.power_down;

  a_oe_deselect: assert property (@(posedge clock) disable iff (rst)
    cs_high |=> !r.so_oe) else $error("output on while deselected");
  a_oe_in_cmd: assert property (@(posedge clock) disable iff (rst)
    (r.phase == PH_CMD) |-> !r.so_oe) else $error("output on during input");
  a_oe_on_fall: assert property (@(posedge clock) disable iff (rst)
    $rose(r.so_oe) |-> $past(sck_fall)) else $error("output enabled off a fall");
  a_mode_latch: assert property (@(posedge clock) disable iff (rst)
    cs_fall |=> (r.mode3 == $past(r.pin_s2[1]))) else $error("mode not latched");
  a_read_fetch: assert property (@(posedge clock) disable iff (rst)
    (byte_done && r.phase == PH_CMD && r.opcode == OP_READ && r.byte_cnt == 3'h3)
    |=> r.mem_rd && r.phase == PH_OUT) else $error("read fetch missing");
  a_fast_fetch: assert property (@(posedge clock) disable iff (rst)
    (byte_done && r.phase == PH_CMD && r.opcode == OP_FAST_READ && r.byte_cnt == 3'h3)
    |=> r.phase == PH_CMD) else $error("fast read left early");
  a_addr_step: assert property (@(posedge clock) disable iff (rst)
    (r.mem_rd && r.src == SRC_MEM) |-> (r.addr == r.mem_addr + 1'b1))
    else $error("read address not stepped");
  a_wel_done: assert property (@(posedge clock) disable iff (rst)
    (arr_done && !cs_rise) |=> !r.wel) else $error("latch kept after done");
  a_chip_prot: assert property (@(posedge clock) disable iff (rst)
    (r.arr_valid && r.arr_kind == ARR_CHIP_ERASE) |-> (r.bp == 2'h0))
    else $error("chip erase while protected");
  a_stat_guard: assert property (@(posedge clock) disable iff (rst)
    ($changed(r.bp) || $changed(r.swp)) |-> $past(r.wel) && ($past(r.pin_s2[3]) || !$past(r.swp)))
    else $error("status written without permission");
  a_sleep_ignore: assert property (@(posedge clock) disable iff (rst)
    (byte_done && r.phase == PH_CMD && r.byte_cnt == 3'h0 && r.power_down
     && byte_in != OP_ID_WAKE) |=> r.phase == PH_IGNORE) else $error("command in power down");

endmodule // sfcp_cmd_port

// file: testbench/sfcp_host.sv
// SPI host model driving select, serial clock and data of the flash port.
// Assumes calls start just after a system clock edge; bit time 800 ns.
`timescale 1ns/1ps
module sfcp_host (
  // Serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // Select or release; sck rests at the mode level around the select edge
  task automatic sel(input logic on, input logic m3);
    #400 sck = m3;
    #400 cs_n = ~on;
    #400;
  endtask
  // One byte msb first; rx takes so at each rise, unknown while so is off
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si  = tx[i];
      #400 sck = 1'b1;
      rx[i] = so_oe ? so : 1'bx;
      #400;
    end
    si = ~si;
  endtask
endmodule // sfcp_host

// file: testbench/sfcp_cmd_port_tb.sv
// Self-checking bench of the flash command port with host and array models.
// Assumes sfcp_host and the design package are compiled first.
`timescale 1ns/1ps
module sfcp_cmd_port_tb;
  import sfcp_pkg::*;
  logic        clock, rst, wp_n, cs_n, sck, si, so, so_oe, mem_rd, ready, done;
  logic        arr_v, pd_v, pdown;
  logic [17:0] mem_addr, arr_a;
  logic [7:0]  mem_rdata, pd_b, fstat, rx, st;
  logic [19:0] cmd_last;
  logic [31:0] seed = 32'h2323;
  logic [23:0] a;
  sfcp_arr_e   arr_k;
  logic [7:0]  q[$], got[$], tx[$];
  int          failures, tests_run, cyc, ncmd;

  sfcp_host H (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
  sfcp_cmd_port DUT (.clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .write_protect_n(wp_n), .so(so), .so_oe(so_oe), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .arr_cmd_valid(arr_v), .arr_cmd_kind(arr_k),
    .arr_cmd_addr(arr_a), .arr_done(done), .program_data_byte(pd_b),
    .program_data_valid(pd_v), .program_data_ready(ready), .flash_status(fstat),
    .power_down(pdown));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] mval(input logic [17:0] ad);
    return ad[7:0] ^ ad[17:10];
  endfunction

  // Array model with one cycle read latency; command capture; hang guard
  always @(posedge clock) begin
    cyc++;
    if (arr_v === 1'b1) begin
      ncmd++;
      cmd_last = {arr_k, arr_a};
    end
    mem_rdata <= mem_rd ? mval(mem_addr) : ~mem_rdata;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end

  task automatic cmp(input logic [19:0] g, input logic [19:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    cmp({12'h0, g}, {12'h0, e});
  endtask
  task automatic chk_cmd(input logic [19:0] g, input logic [19:0] e);
    cmp(g, e);
  endtask

  task automatic run(input logic [7:0] t[$], input int nrx, input logic m3);
    @(posedge clock);
    #1 H.sel(1'b1, m3);
    foreach (t[i]) H.xfer(t[i], rx);
    got.delete();
    repeat (nrx) begin
      H.xfer(8'h00, rx);
      got.push_back(rx);
    end
    H.sel(1'b0, m3);
    repeat (6) @(posedge clock);
  endtask
  // Status read twice in a row: the byte repeats
  task automatic stat(input logic m3);
    run('{OP_STAT_READ}, 2, m3);
    chk_byte(got[0], st);
    chk_byte(got[1], st);
    chk_byte(fstat, st);
  endtask
  // Write enable, command, then a done pulse when the command was issued
  task automatic arr(input logic [7:0] t[$], input logic [19:0] e, input bit ok);
    int n0;
    n0 = ncmd;
    run('{OP_WRITE_EN}, 0, 1'b0);
    run(t, 0, 1'b0);
    chk_cmd(20'(ncmd - n0), 20'(ok));
    if (ok) begin
      chk_cmd(cmd_last & (t.size() == 1 ? 20'hc0000 : 20'hfffff), e);
      @(posedge clock);
      #1 done = 1'b1;
      @(posedge clock);
      #1 done = 1'b0;
    end
    // Status write model: lands with write enable unless pin low and flag set
    if (t[0] == OP_STAT_WRITE && t.size() == 2 && (wp_n || !st[7]))
      st = {t[1][7], 3'h0, t[1][3:2], 2'h0};
    else
      st[1] = !ok;
    stat(1'b0);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    ready = 1'b0;
    done = 1'b0;
    mem_rdata = 8'h00;
    st = 8'h00;
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    stat(1'b1);
    run('{OP_WRITE_EN}, 0, 1'b0);
    st = 8'h02;
    stat(1'b0);
    run('{OP_WRITE_DIS}, 0, 1'b0);
    st = 8'h00;
    stat(1'b1);
    for (int k = 0; k < 2; k++) begin
      a = k ? 24'(rnd() | 32'hfc0000) : 24'hfffffe;
      tx = '{k ? OP_FAST_READ : OP_READ, a[23:16], a[15:8], a[7:0]};
      if (k) tx.push_back(8'(rnd()));
      run(tx, 3, k[0]);
      for (int i = 0; i < 3; i++) chk_byte(got[i], mval(18'(a[17:0] + i)));
      chk_byte({7'h0, so_oe}, 8'h00);
    end
    run('{OP_ID_READ}, 2, 1'b0);
    chk_cmd({4'h0, got[0], got[1]}, {4'h0, ID_MAKER, ID_DEVICE});
    run('{OP_ID_WAKE, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
    chk_byte(got[0], ID_DEVICE);
    run('{8'h77}, 1, 1'b0);
    chk_byte(got[0], 8'hxx);
    run('{OP_POWER_DOWN}, 0, 1'b0);
    chk_byte({7'h0, pdown}, 8'h01);
    run('{OP_STAT_READ}, 1, 1'b0);
    chk_byte(got[0], 8'hxx);
    run('{OP_ID_WAKE}, 0, 1'b0);
    chk_byte({7'h0, pdown}, 8'h00);
    arr('{OP_CHIP_ERASE}, {ARR_CHIP_ERASE, 18'h0}, 1'b1);
    arr('{OP_STAT_WRITE, 8'hff}, 20'h0, 1'b0);
    st = 8'h8c;
    stat(1'b0);
    wp_n = 1'b0;
    arr('{OP_STAT_WRITE, 8'h00}, 20'h0, 1'b0);
    arr('{OP_CHIP_ERASE}, 20'h0, 1'b0);
    wp_n = 1'b1;
    run('{OP_STAT_WRITE, 8'h00}, 0, 1'b0);
    st = 8'h00;
    stat(1'b0);
    arr('{OP_SECT_ERASE, 8'h01, 8'h02}, 20'h0, 1'b0);
    run('{OP_WRITE_DIS}, 0, 1'b0);
    st = 8'h00;
    foreach (tx[i]) tx[i] = 8'(rnd());
    arr('{OP_SSE_A, tx[0], tx[1], tx[2]}, {ARR_SMALL_ERASE, tx[0][1:0], tx[1], tx[2]}, 1'b1);
    arr('{OP_SSE_B, tx[2], tx[1], 8'h00}, {ARR_SMALL_ERASE, tx[2][1:0], tx[1], 8'h00}, 1'b1);
    arr('{OP_SECT_ERASE, tx[1], tx[0], tx[3]}, {ARR_SECTOR_ERASE, tx[1][1:0], tx[0], tx[3]},
      1'b1);
    q.delete();
    tx = '{OP_PAGE_PROG, 8'h03, 8'h10, 8'h00};
    repeat (FIFO_DEPTH) begin
      q.push_back(8'(rnd()));
      tx.push_back(q[$]);
    end
    arr(tx, {ARR_PROGRAM, 18'h31000}, 1'b1);
    while (q.size() > 0 && cyc < 59000) begin
      @(posedge clock);
      if (ready && pd_v === 1'b1) chk_byte(pd_b, q.pop_front());
      #1 ready = 1'(rnd());
    end
    ready = 1'b0;
    chk_byte({7'h0, pd_v}, 8'h00);
    end_sim();
  end
endmodule // sfcp_cmd_port_tb
